/* inc/ncfg_pkg.sv */
/*
 * Constants of the configuration byte bank: offsets, field positions and
 * reset values. Assumes the user includes nothing else and uses ncfg_pkg::.
 */
`default_nettype none
package ncfg_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_FEATURE_SETUP_A = 8'h52;
	localparam logic [7:0] OFF_FEATURE_SETUP_B = 8'h53;
	localparam logic [7:0] OFF_CARDBUS_CFG     = 8'h54;

	// ----------------------------------------------------------------
	// Field positions of feature_setup_a
	// ----------------------------------------------------------------
	localparam int A_IO_SPACE_MAPPED    = 2;
	localparam int A_VPD_ENABLE         = 1;
	localparam int A_POWER_EVENT_ENABLE = 0;

	// ----------------------------------------------------------------
	// Field positions of feature_setup_b and of the CardBus configuration byte
	// ----------------------------------------------------------------
	localparam int B_RESERVED           = 7;
	localparam int B_REMOTE_MGMT_ENABLE = 6;
	localparam int B_MSI_ENABLE         = 5;
	localparam int B_AUX_STATUS         = 4;
	localparam int B_SLOT_WIDTH_FLAG    = 3;
	localparam int B_CLK_FREQ_HI        = 2;
	localparam int B_CLK_FREQ_LO        = 0;
	localparam int CARDBUS_MODE_BIT     = 3;

	// ----------------------------------------------------------------
	// Reset and constant values
	// ----------------------------------------------------------------
	localparam logic       RESERVED_READ_VALUE = 1'h1;
	localparam logic       REMOTE_MGMT_RESET   = 1'h0;
	localparam logic       MSI_RESET           = 1'h0;
	localparam logic       VPD_RESET           = 1'h0;
	localparam logic       POWER_EVENT_RESET   = 1'h0;
	localparam logic       AUX_STATUS_RESET    = 1'h0;
	localparam logic [7:0] READ_ZERO           = 8'h00;
	localparam logic [7:0] VPD_EEPROM_FIRST    = 8'h40;
	localparam logic [7:0] VPD_EEPROM_LAST     = 8'h7F;
	localparam int         SYNC_STAGES         = 2;
endpackage : ncfg_pkg
`default_nettype wire

/* hdl/ncfg_sync.sv */
/*
 * Two-flop synchroniser for a group of level inputs from the pins.
 * Assumes the inputs are quasi-static levels, not pulses.
 */
`default_nettype none
module ncfg_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic             clk_en_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else if (clk_en_i) begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule : ncfg_sync
`default_nettype wire

/* hdl/ncfg_bank.sv */
/*
 * Configuration byte bank: feature_setup_a (lower fields) and
 * feature_setup_b, with autoload from the configuration EEPROM.
 * Assumes a simple byte register port on sys_clk_i and an autoload engine
 * that presents the stored byte with a one-cycle done strobe.
 */
`default_nettype none
module ncfg_bank (
	// Clock, reset, enable
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	// Register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_rvalid_o,
	// EEPROM autoload
	input  wire logic       autoload_done_i,
	input  wire logic [7:0] eeprom_cfg_i,
	// Same-clock status from neighbouring logic
	input  wire logic       cardbus_mode_i,
	input  wire logic       io_space_mapped_i,
	// Pins
	input  wire logic       pci_rst_pin_i,
	input  wire logic       aux_power_pin_i,
	input  wire logic       slot_width_pin_i,
	input  wire logic [2:0] bus_clock_freq_pin_i,
	// Feature controls
	output logic            remote_mgmt_enable_o,
	output logic            asf_autoload_en_o,
	output logic            smbus_enable_o,
	output logic            smbus_arp_enable_o,
	output logic            msi_enable_o,
	output logic            vpd_enable_o,
	output logic            power_event_enable_o
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pins_sync;

	ncfg_sync #(
		.WIDTH (6)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.clk_en_i  (clk_en_i),
		.async_i   ({pci_rst_pin_i, aux_power_pin_i, slot_width_pin_i, bus_clock_freq_pin_i}),
		.sync_o    (pins_sync)
	);

	wire       pci_rst_s    = pins_sync[5];
	wire       aux_power_s  = pins_sync[4];
	wire       slot_width_s = pins_sync[3];
	wire [2:0] clk_freq_s   = pins_sync[2:0];

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire hit_a = (reg_addr_i == ncfg_pkg::OFF_FEATURE_SETUP_A);
	wire hit_b = (reg_addr_i == ncfg_pkg::OFF_FEATURE_SETUP_B);
	wire wr_a  = reg_wr_i && hit_a;
	wire wr_b  = reg_wr_i && hit_b;

	logic remote_mgmt_reg, remote_mgmt_next;
	logic msi_reg,         msi_next;
	logic vpd_reg,         vpd_next;
	logic pev_reg,         pev_next;
	logic aux_status_reg,  aux_status_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg;

	// Autoload wins over a software write in the same cycle
	wire load_mgmt = eeprom_cfg_i[ncfg_pkg::B_REMOTE_MGMT_ENABLE];
	wire wr_mgmt   = reg_wdata_i[ncfg_pkg::B_REMOTE_MGMT_ENABLE];

	assign remote_mgmt_next = cardbus_mode_i ? 1'h0 :
		autoload_done_i ? load_mgmt :
		wr_b ? wr_mgmt : remote_mgmt_reg;
	assign msi_next = autoload_done_i ? eeprom_cfg_i[ncfg_pkg::B_MSI_ENABLE] :
		wr_b ? reg_wdata_i[ncfg_pkg::B_MSI_ENABLE] : msi_reg;
	assign vpd_next = wr_a ? reg_wdata_i[ncfg_pkg::A_VPD_ENABLE] : vpd_reg;
	assign pev_next = wr_a ? reg_wdata_i[ncfg_pkg::A_POWER_EVENT_ENABLE] : pev_reg;
	// Tracks the pin while PCI reset is held, frozen once it is released
	assign aux_status_next = pci_rst_s ? aux_power_s : aux_status_reg;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	wire [7:0] byte_a = {5'h00, io_space_mapped_i, vpd_reg, pev_reg};
	wire [7:0] byte_b = {ncfg_pkg::RESERVED_READ_VALUE, remote_mgmt_reg,
		msi_reg, aux_status_reg, slot_width_s, clk_freq_s};

	assign rdata_next = hit_a ? byte_a :
		hit_b ? byte_b : ncfg_pkg::READ_ZERO;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			remote_mgmt_reg <= ncfg_pkg::REMOTE_MGMT_RESET;
			msi_reg         <= ncfg_pkg::MSI_RESET;
			vpd_reg         <= ncfg_pkg::VPD_RESET;
			pev_reg         <= ncfg_pkg::POWER_EVENT_RESET;
			aux_status_reg  <= ncfg_pkg::AUX_STATUS_RESET;
		end else if (clk_en_i) begin
			remote_mgmt_reg <= remote_mgmt_next;
			msi_reg         <= msi_next;
			vpd_reg         <= vpd_next;
			pev_reg         <= pev_next;
			aux_status_reg  <= aux_status_next;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg  <= ncfg_pkg::READ_ZERO;
			rvalid_reg <= 1'h0;
		end else if (clk_en_i) begin
			rvalid_reg <= reg_rd_i;
			if (reg_rd_i) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o          = rdata_reg;
	assign reg_rvalid_o         = rvalid_reg;
	assign remote_mgmt_enable_o = remote_mgmt_reg;
	assign asf_autoload_en_o    = remote_mgmt_reg;
	assign smbus_enable_o       = remote_mgmt_reg;
	assign smbus_arp_enable_o   = remote_mgmt_reg;
	assign msi_enable_o         = msi_reg;
	assign vpd_enable_o         = vpd_reg;
	assign power_event_enable_o = pev_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_mgmt_autoload: assert property (clk_en_i && autoload_done_i && !cardbus_mode_i
		|=> remote_mgmt_enable_o == $past(eeprom_cfg_i[ncfg_pkg::B_REMOTE_MGMT_ENABLE]))
		else $error("remote management not loaded from EEPROM byte");
	a_mgmt_cardbus_excl: assert property (clk_en_i && cardbus_mode_i
		|=> !remote_mgmt_enable_o)
		else $error("remote management on with CardBus mode");
	a_asf_smbus_on: assert property (remote_mgmt_enable_o
		|-> asf_autoload_en_o && smbus_enable_o && smbus_arp_enable_o)
		else $error("ASF or SMBus off while remote management on");
	a_asf_smbus_off: assert property (!remote_mgmt_enable_o
		|-> !asf_autoload_en_o && !smbus_enable_o && !smbus_arp_enable_o)
		else $error("ASF or SMBus active while remote management off");
	a_msi_autoload: assert property (clk_en_i && autoload_done_i
		|=> msi_enable_o == $past(eeprom_cfg_i[ncfg_pkg::B_MSI_ENABLE]))
		else $error("MSI enable not loaded from EEPROM byte");
	a_aux_held: assert property (!pci_rst_s && clk_en_i
		|=> $stable(aux_status_reg))
		else $error("aux status changed outside PCI reset");
	a_vpd_write: assert property (clk_en_i && wr_a
		|=> vpd_enable_o == $past(reg_wdata_i[ncfg_pkg::A_VPD_ENABLE]))
		else $error("VPD enable write lost");
	a_io_space_mapped_read: assert property (clk_en_i && reg_rd_i && hit_a
		|=> reg_rvalid_o
		&& reg_rdata_o[ncfg_pkg::A_IO_SPACE_MAPPED] == $past(io_space_mapped_i))
		else $error("I/O mapped bit read wrong");
	a_reserved_read: assert property (clk_en_i && reg_rd_i && hit_b
		|=> reg_rdata_o[ncfg_pkg::B_RESERVED] == ncfg_pkg::RESERVED_READ_VALUE)
		else $error("reserved bit does not read one");
	a_unmapped_zero: assert property (clk_en_i && reg_rd_i && !hit_a && !hit_b
		|=> reg_rvalid_o && reg_rdata_o == ncfg_pkg::READ_ZERO)
		else $error("unmapped read not zero");

	// ----------------------------------------------------------------
	// Register port, hold and aux tracking checks, then covers
	// ----------------------------------------------------------------
	a_aux_track: assert property (clk_en_i && pci_rst_s
		|=> aux_status_reg == $past(aux_power_s))
		else $error("aux status not tracking pin during PCI reset");
	a_aux_read: assert property (clk_en_i && reg_rd_i && hit_b
		|=> reg_rdata_o[ncfg_pkg::B_AUX_STATUS] == $past(aux_status_reg))
		else $error("aux status bit read wrong");
	a_vpd_hold: assert property (!(clk_en_i && wr_a)
		|=> $stable(vpd_enable_o))
		else $error("VPD enable changed without a write");
	a_msi_write: assert property (clk_en_i && wr_b && !autoload_done_i
		|=> msi_enable_o == $past(reg_wdata_i[ncfg_pkg::B_MSI_ENABLE]))
		else $error("MSI enable write lost");
	a_mgmt_hold_off: assert property (!remote_mgmt_enable_o
		&& !autoload_done_i && !wr_b |=> !remote_mgmt_enable_o)
		else $error("remote management turned on without load or write");
	a_pev_write: assert property (clk_en_i && wr_a
		|=> power_event_enable_o == $past(reg_wdata_i[ncfg_pkg::A_POWER_EVENT_ENABLE]))
		else $error("power event enable write lost");
	a_rvalid_follows: assert property (clk_en_i && reg_rd_i
		|=> reg_rvalid_o)
		else $error("read answer missing");
	a_rvalid_only: assert property (clk_en_i && !reg_rd_i
		|=> !reg_rvalid_o)
		else $error("read answer without a read");

	c_autoload_on: cover property (autoload_done_i && eeprom_cfg_i[6] ##1 remote_mgmt_enable_o);
	c_cardbus_block: cover property (cardbus_mode_i && autoload_done_i && eeprom_cfg_i[6]);
	c_aux_capture: cover property (pci_rst_s ##1 !pci_rst_s);
	c_read_b: cover property (reg_rd_i && hit_b ##1 reg_rvalid_o);
	c_vpd_write: cover property (wr_a && reg_wdata_i[ncfg_pkg::A_VPD_ENABLE]);
endmodule : ncfg_bank
`default_nettype wire

/* bench/ncfg_eeprom_model.sv */
/*
 * Configuration EEPROM autoload source: presents one byte with a done pulse.
 * Assumes the bench requests each load with a one-cycle load_i pulse.
 */
`default_nettype none
module ncfg_eeprom_model (
	// Clock
	input  wire logic       sys_clk_i,
	// Request
	input  wire logic       load_i,
	input  wire logic [7:0] byte_i,
	// Autoload port
	output logic            done_o,
	output logic      [7:0] cfg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Byte only valid with done; toggles otherwise so a stale read shows
	always_ff @(posedge sys_clk_i) begin
		done_o <= load_i;
		cfg_o  <= load_i ? byte_i : ~cfg_o;
	end
endmodule : ncfg_eeprom_model
`default_nettype wire

/* bench/ncfg_bank_tb.sv */
/*
 * Self-checking bench for ncfg_bank.
 * Assumes the EEPROM model drives the autoload port.
 */
`default_nettype none
module ncfg_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'h0, rst_i = 1'h1, wr = 1'h0, rd = 1'h0, ld = 1'h0, cb = 1'h0;
	logic io = 1'h0, prst = 1'h0, aux = 1'h0, rv, done, rme, asf, smb, arp, msi, vpd, pe;
	logic [7:0] ad = 8'h00, wd = 8'h00, lb = 8'h00, rdat, cfg, d;
	int err_count = 0;
	int samples_checked = 0;
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
	ncfg_eeprom_model ee_u (.sys_clk_i(sys_clk_i), .load_i(ld), .byte_i(lb), .done_o(done),
		.cfg_o(cfg));
	ncfg_bank dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(1'h1),
		.reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
		.reg_rdata_o(rdat), .reg_rvalid_o(rv), .autoload_done_i(done),
		.eeprom_cfg_i(cfg), .cardbus_mode_i(cb), .io_space_mapped_i(io),
		.pci_rst_pin_i(prst), .aux_power_pin_i(aux), .slot_width_pin_i(1'h1),
		.bus_clock_freq_pin_i(3'h1), .remote_mgmt_enable_o(rme),
		.asf_autoload_en_o(asf), .smbus_enable_o(smb), .smbus_arp_enable_o(arp),
		.msi_enable_o(msi), .vpd_enable_o(vpd), .power_event_enable_o(pe));
	initial begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : tick
	// Read answer waited for under a bound; a lost answer ends the run
	task automatic rd_b(input logic [7:0] a);
		int i;
		@(posedge sys_clk_i);
		ad <= a;
		rd <= 1'h1;
		@(posedge sys_clk_i);
		rd <= 1'h0;
		for (i = 0; i < 4 && rv !== 1'h1; i++) begin
			#1;
			if (rv !== 1'h1) @(posedge sys_clk_i);
		end
		if (rv !== 1'h1) begin
			err_count++;
			end_sim();
		end
		d = rdat;
	endtask : rd_b
	task automatic wr_b(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		ad <= a;
		wd <= v;
		wr <= 1'h1;
		@(posedge sys_clk_i);
		wr <= 1'h0;
		tick(2);
	endtask : wr_b
	task automatic load(input logic [7:0] b);
		@(posedge sys_clk_i);
		ld <= 1'h1;
		lb <= b;
		@(posedge sys_clk_i);
		ld <= 1'h0;
		tick(3);
	endtask : load
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd_b(8'h53);
		`CHK("b_reset", 8'h89, d)
		rd_b(8'h52);
		`CHK("a_reset", 8'h00, d)
		rd_b(8'h10);
		`CHK("unmapped", 8'h00, d)
	endtask : t_reset
	task automatic t_load;
		load(8'h60);
		`CHK("rm_on", 4'hF, {rme, asf, smb, arp})
		`CHK("msi_on", 1'h1, msi)
		load(8'h00);
		`CHK("rm_off", 5'h00, {rme, asf, smb, arp, msi})
	endtask : t_load
	task automatic t_cardbus;
		cb <= 1'h1;
		load(8'h40);
		`CHK("cb_load", 2'h0, {rme, smb})
		wr_b(8'h53, 8'h40);
		`CHK("cb_wr", 2'h0, {rme, smb})
		cb <= 1'h0;
	endtask : t_cardbus
	task automatic t_regs;
		io <= 1'h1;
		wr_b(8'h52, 8'hFA);
		`CHK("vpd", 1'h1, vpd)
		rd_b(8'h52);
		`CHK("a_rd", 8'h06, d)
		wr_b(8'h52, 8'h01);
		`CHK("pe_vpd", 2'h1, {vpd, pe})
		wr_b(8'h53, 8'h20);
		`CHK("msi_wr", 2'h1, {rme, msi})
		rd_b(8'h53);
		`CHK("b_rd", 8'hA9, d)
	endtask : t_regs
	task automatic t_aux;
		prst <= 1'h1;
		aux <= 1'h1;
		tick(5);
		prst <= 1'h0;
		tick(5);
		aux <= 1'h0;
		tick(5);
		rd_b(8'h53);
		`CHK("aux_held", 1'h1, d[4])
	endtask : t_aux
	initial begin
		tick(5);
		rst_i <= 1'h0;
		// Pin levels need two edges through the synchroniser
		tick(2);
		t_reset();
		t_load();
		t_cardbus();
		t_regs();
		t_aux();
		end_sim();
	end
endmodule : ncfg_bank_tb
`default_nettype wire
